/* pkg/mmpc_consts.vh */
/*
 constants for the memory map and page control block: register offsets, reset
 values, fixed page numbers and window bounds. assumes plain verilog-2005 includes.
*/
`ifndef MMPC_CONSTS_VH
`define MMPC_CONSTS_VH

`define MMPC_OFF_MODE      8'h0b
`define MMPC_OFF_DIRECT    8'h11
`define MMPC_OFF_PROGRAM_PAGE_INDEX     8'h15
`define MMPC_OFF_DBGPAGE   8'h16
`define MMPC_MODE_BIT      7
`define MMPC_PROGRAM_PAGE_INDEX_RST     4'he
`define MMPC_DBGPAGE_RST   4'he
`define MMPC_DIRECT_RST    8'h00
`define MMPC_PAGE_LO       4'hc
`define MMPC_PAGE_MID      4'hd
`define MMPC_PAGE_TOP      4'hf
`define MMPC_DBG_HI_PAGE   4'hf
`define MMPC_DBG_WIN_HI    8'hff
`define MMPC_DBG_WIN_PP    8'hbf
`define MMPC_ALLOW_NS2SS   1'b0
`define MMPC_ALLOW_SS2NS   1'b1

`endif

/* hdl/mmpc_addr_xlate.v */
/*
 local to global address expansion for one master.
 assumes the page index comes from a register of the caller; purely combinational.
*/
`timescale 1ns/1ps
`include "mmpc_consts.vh"

module mmpc_addr_xlate (
   input  wire [15:0] local_addr_i,
   input  wire [3:0]  page_index_bits_i,
   output wire [17:0] global_addr_o
);

   reg [3:0] page_sel;

   // the top two local bits pick a fixed page or the program page window
   always @* begin
      case (local_addr_i[15:14])
         2'b00:   page_sel = `MMPC_PAGE_LO;
         2'b01:   page_sel = `MMPC_PAGE_MID;
         2'b10:   page_sel = page_index_bits_i;
         default: page_sel = `MMPC_PAGE_TOP;
      endcase
   end

   // page sits above local bits 13..0
   assign global_addr_o = {page_sel, local_addr_i[13:0]};

endmodule // mmpc_addr_xlate

/* hdl/mmpc_page_ctrl.v */
/*
 memory map and page control: mode select bit, direct page, program page and
 debug page registers, address expansion and debug resource decode.
 assumes the cpu and debug masters share the bus clock and the system reset,
 and that register accesses arrive as single-cycle strobes with an 8-bit offset.
*/
`timescale 1ns/1ps
`include "mmpc_consts.vh"

// Function
// - mode select bit rules the mode out of reset; pin rules during reset
// - pin level is captured into mode select bit at reset release
// - disallowed mode write leaves bit and locks later writes, except special mode
// - mode register writes are ignored while secured
// - direct page writable always in special mode, only once in normal mode
// - direct page bits form local address bits 15..8 for direct addressing
// - page index bits select the 16KB block seen at 0x8000-0xBFFF
// - far call/return page writes complete within the same cycle
// - local 0x0000-0x3FFF maps to fixed page 0x0C
// - local 0x4000-0x7FFF maps to fixed page 0x0D
// - local 0xC000-0xFFFF maps to fixed page 0x0F
// - program page resets to 0x0E for linear flash
// - debug resources selected only in debug read and write cycles
// - active debug decodes 0xFF00-0xFFFF to debug tables
// - active debug with page 0x0F also decodes 0xBF00-0xBFFF
// - debug page register has four bits, expands like the cpu page
// - debug page used only when enabled and for firmware or hardware commands
// - debug master reads and writes program and debug page registers
// - special single-chip mode enters active debug after every reset
module mmpc_page_ctrl (
   input  wire        clock_i,
   input  wire        arst_n_i,
   input  wire        mode_pin_i,
   input  wire        secured_i,
   input  wire        allow_ns2ss_i,
   input  wire        allow_ss2ns_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [7:0]  reg_addr_i,
   input  wire [7:0]  reg_wdata_i,
   output reg  [7:0]  reg_rdata_o,
   input  wire        far_page_wr_i,
   input  wire [3:0]  far_page_i,
   input  wire [15:0] cpu_addr_i,
   input  wire        cpu_direct_i,
   output wire [17:0] cpu_global_o,
   input  wire [15:0] dbg_addr_i,
   input  wire        dbg_page_en_i,
   input  wire        dbg_cmd_i,
   input  wire        debug_read_cycle_i,
   input  wire        debug_write_cycle_i,
   input  wire        debug_active_i,
   output wire [17:0] dbg_global_o,
   output wire        dbg_res_sel_o,
   output wire        special_mode_o,
   output wire        debug_entry_o
);

   reg        mode_select_bit_q;
   reg        mode_lock_q;
   reg        in_reset_q;
   reg [7:0]  direct_page_bits_q;
   reg        direct_written_q;
   reg [3:0]  program_page_index_q;
   reg [3:0]  debug_page_register_q;
   reg        debug_entry_q;

   wire [15:0] cpu_local;
   wire [3:0]  dbg_page;
   wire        wr_mode;
   wire        wr_direct;
   wire        wr_program_page_index;
   wire        wr_dbgpage;
   wire        mode_allowed;

   // table lookup of a permitted transition; table is held on ports and
   // tied off by the integrator so it can change without touching this file
   function mode_ok;
      input cur;
      input nxt;
      input ns2ss;
      input ss2ns;
      begin
         if (cur == nxt)
            mode_ok = 1'b1;
         else if (nxt)
            mode_ok = ns2ss;
         else
            mode_ok = ss2ns;
      end
   endfunction

   // address decode of register strobes
   assign wr_mode    = reg_wr_i && (reg_addr_i == `MMPC_OFF_MODE);
   assign wr_direct  = reg_wr_i && (reg_addr_i == `MMPC_OFF_DIRECT);
   assign wr_program_page_index   = reg_wr_i && (reg_addr_i == `MMPC_OFF_PROGRAM_PAGE_INDEX);
   assign wr_dbgpage = reg_wr_i && (reg_addr_i == `MMPC_OFF_DBGPAGE);
   assign mode_allowed = mode_ok(mode_select_bit_q, reg_wdata_i[`MMPC_MODE_BIT],
                                 allow_ns2ss_i, allow_ss2ns_i);

   // the mode pin is sampled while reset was seen last cycle, so the capture
   // happens at the first edge after release, never inside the async branch
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         in_reset_q        <= 1'b1;
         mode_select_bit_q <= 1'b0;
         mode_lock_q       <= 1'b0;
         debug_entry_q     <= 1'b0;
      end else begin
         in_reset_q <= 1'b0;
         if (in_reset_q) begin
            mode_select_bit_q <= mode_pin_i;
            debug_entry_q     <= mode_pin_i;
         end else begin
            debug_entry_q <= 1'b0;
            if (wr_mode && !secured_i) begin
               if (mode_select_bit_q || (!mode_lock_q && mode_allowed)) begin
                  if (mode_allowed)
                     mode_select_bit_q <= reg_wdata_i[`MMPC_MODE_BIT];
               end
               if (!mode_allowed && !mode_select_bit_q)
                  mode_lock_q <= 1'b1;
            end
         end
      end
   end

   // pin governs during the capture cycle, the register afterwards
   assign special_mode_o = in_reset_q ? mode_pin_i : mode_select_bit_q;
   assign debug_entry_o  = debug_entry_q;

   // direct page: one write in normal mode, any number in special mode
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         direct_page_bits_q <= `MMPC_DIRECT_RST;
         direct_written_q   <= 1'b0;
      end else if (wr_direct && (mode_select_bit_q || !direct_written_q)) begin
         direct_page_bits_q <= reg_wdata_i;
         direct_written_q   <= 1'b1;
      end
   end

   // program page: far call/return path wins so it lands within its cycle
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         program_page_index_q  <= `MMPC_PROGRAM_PAGE_INDEX_RST;
         debug_page_register_q <= `MMPC_DBGPAGE_RST;
      end else begin
         if (far_page_wr_i)
            program_page_index_q <= far_page_i;
         else if (wr_program_page_index)
            program_page_index_q <= reg_wdata_i[3:0];
         if (wr_dbgpage)
            debug_page_register_q <= reg_wdata_i[3:0];
      end
   end

   // read data registered; unmapped offsets read zero
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i) begin
         if (reg_addr_i == `MMPC_OFF_MODE)
            reg_rdata_o <= {mode_select_bit_q, 7'h00};
         else if (reg_addr_i == `MMPC_OFF_DIRECT)
            reg_rdata_o <= direct_page_bits_q;
         else if (reg_addr_i == `MMPC_OFF_PROGRAM_PAGE_INDEX)
            reg_rdata_o <= {4'h0, program_page_index_q};
         else if (reg_addr_i == `MMPC_OFF_DBGPAGE)
            reg_rdata_o <= {4'h0, debug_page_register_q};
         else
            reg_rdata_o <= 8'h00;
      end
   end

   // direct addressing replaces the high byte with the direct page
   assign cpu_local = cpu_direct_i ? {direct_page_bits_q, cpu_addr_i[7:0]}
                                   : cpu_addr_i;

   mmpc_addr_xlate u_cpu_xlate (
      .local_addr_i      (cpu_local),
      .page_index_bits_i (program_page_index_q),
      .global_addr_o     (cpu_global_o)
   );

   // debug page only when enabled and a command is running
   assign dbg_page = (dbg_page_en_i && dbg_cmd_i) ? debug_page_register_q
                                                  : program_page_index_q;

   mmpc_addr_xlate u_dbg_xlate (
      .local_addr_i      (dbg_addr_i),
      .page_index_bits_i (dbg_page),
      .global_addr_o     (dbg_global_o)
   );

   // debug resources hide others only in dedicated cycles of active debug
   assign dbg_res_sel_o = (debug_read_cycle_i || debug_write_cycle_i)
      && debug_active_i
      && ((dbg_addr_i[15:8] == `MMPC_DBG_WIN_HI)
          || ((dbg_addr_i[15:8] == `MMPC_DBG_WIN_PP)
              && (program_page_index_q == `MMPC_DBG_HI_PAGE)));

endmodule // mmpc_page_ctrl

/* testbench/mmpc_master_model.sv */
/* cpu or debug bus master model for the register port.
   assumes the caller enters each task just after a falling edge */
`timescale 1ns/1ps
module mmpc_master_model (
   input  wire       clock_i,
   output reg        reg_wr_o,
   output reg        reg_rd_o,
   output reg  [7:0] reg_addr_o,
   output reg  [7:0] reg_wdata_o
);
   // idle the port from time zero so no unknown strobe reaches the first edge after reset
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // one access held over one edge, then one idle cycle so strobes never toggle twice
   task acc(input w, input [7:0] a, input [7:0] d);
      begin
         reg_wr_o = w;
         reg_rd_o = !w;
         reg_addr_o = a;
         reg_wdata_o = d;
         @(negedge clock_i);
         reg_wr_o = 0;
         reg_rd_o = 0;
         reg_addr_o = ~a;
         @(negedge clock_i);
      end
   endtask
endmodule // mmpc_master_model

/* testbench/mmpc_page_ctrl_monitor.sv */
/* port checker for the page control block.
   assumes one clock domain and the bind below */
`timescale 1ns/1ps
module mmpc_page_ctrl_monitor (
   input wire        clock_i, arst_n_i, secured_i, reg_wr_i, reg_rd_i,
   input wire [7:0]  reg_addr_i, reg_rdata_o,
   input wire        far_page_wr_i, cpu_direct_i, debug_read_cycle_i, debug_write_cycle_i,
   input wire [3:0]  far_page_i,
   input wire [15:0] cpu_addr_i,
   input wire [17:0] cpu_global_o,
   input wire        dbg_res_sel_o, special_mode_o, debug_entry_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   wire loc = !cpu_direct_i;
   a_low_page: assert property (loc && cpu_addr_i[15:14] == 2'h0 |-> cpu_global_o == {4'hc, cpu_addr_i[13:0]}) else $error("low page");
   a_mid_page: assert property (loc && cpu_addr_i[15:14] == 2'h1 |-> cpu_global_o == {4'hd, cpu_addr_i[13:0]}) else $error("mid page");
   a_top_page: assert property (loc && cpu_addr_i[15:14] == 2'h3 |-> cpu_global_o == {4'hf, cpu_addr_i[13:0]}) else $error("top page");
   a_far_page_now: assert property (far_page_wr_i ##1 (loc && cpu_addr_i[15:14] == 2'h2) |-> cpu_global_o == {$past(far_page_i), cpu_addr_i[13:0]}) else $error("far page late");
   a_direct_low: assert property (cpu_direct_i |-> cpu_global_o[7:0] == cpu_addr_i[7:0]) else $error("direct low byte");
   a_no_dbg_sel: assert property (!debug_read_cycle_i && !debug_write_cycle_i |-> !dbg_res_sel_o) else $error("debug select");
   a_entry_once: assert property (debug_entry_o |-> special_mode_o ##1 !debug_entry_o) else $error("entry pulse");
   a_secure_block: assert property (secured_i && reg_wr_i && reg_addr_i == 8'h0b |=> $stable(special_mode_o)) else $error("secured write");
   a_mode_read: assert property (reg_rd_i && reg_addr_i == 8'h0b |=> reg_rdata_o == {$past(special_mode_o), 7'h0}) else $error("mode read");
   c_far: cover property (far_page_wr_i);
   c_entry: cover property (debug_entry_o);
   c_sec: cover property (secured_i && reg_wr_i);
endmodule // mmpc_page_ctrl_monitor
bind mmpc_page_ctrl mmpc_page_ctrl_monitor chk_i (.clock_i, .arst_n_i, .secured_i, .reg_wr_i,
   .reg_rd_i, .reg_addr_i, .reg_rdata_o, .far_page_wr_i, .cpu_direct_i, .debug_read_cycle_i,
   .debug_write_cycle_i, .far_page_i, .cpu_addr_i, .cpu_global_o, .dbg_res_sel_o,
   .special_mode_o, .debug_entry_o);

/* testbench/mmpc_page_ctrl_tb.sv */
/* self-checking bench for the page control block.
   assumes the master model drives the register port */
`timescale 1ns/1ps
module mmpc_page_ctrl_tb;
   reg         clock_i = 0, arst_n_i = 0, pin = 1, sec = 0, a_ns = 0, dir = 0, far = 0;
   reg  [3:0]  fp = 0, p;
   reg  [15:0] ca = 0, da = 0;
   reg  [4:0]  dv = 0; // page_en, cmd, read, write, active
   wire        wr, rd, sel, spec, entry;
   wire [7:0]  ad, wd, rdat;
   wire [17:0] cg, dg;
   integer     n_mismatch = 0, cmp_count = 0, i, r;
   always #4 clock_i = ~clock_i;
   mmpc_master_model m (.clock_i(clock_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(ad),
      .reg_wdata_o(wd));
   mmpc_page_ctrl uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .mode_pin_i(pin),
      .secured_i(sec), .allow_ns2ss_i(a_ns), .allow_ss2ns_i(1'b1), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdat),
      .far_page_wr_i(far), .far_page_i(fp), .cpu_addr_i(ca), .cpu_direct_i(dir),
      .cpu_global_o(cg), .dbg_addr_i(da), .dbg_page_en_i(dv[4]), .dbg_cmd_i(dv[3]),
      .debug_read_cycle_i(dv[2]), .debug_write_cycle_i(dv[1]), .debug_active_i(dv[0]),
      .dbg_global_o(dg), .dbg_res_sel_o(sel), .special_mode_o(spec), .debug_entry_o(entry));
   // expected local to global map
   function [17:0] xmap(input [15:0] a, input [3:0] pp);
      case (a[15:14])
         2'h0: xmap = {4'hc, a[13:0]};
         2'h1: xmap = {4'hd, a[13:0]};
         2'h2: xmap = {pp, a[13:0]};
         default: xmap = {4'hf, a[13:0]};
      endcase
   endfunction
   task chk(input string nm, input [17:0] seen, input [17:0] exp);
      begin
         cmp_count++;
         if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task rdc(input [7:0] a, input [7:0] exp);
      begin
         m.acc(0, a, 8'h00);
         chk("rdata", rdat, exp);
      end
   endtask
   task final_report;
      begin
         $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
         if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // watchdog cuts any hang short
   initial begin
      #200000 n_mismatch++;
      final_report;
   end
   initial begin
      r = $urandom(18447);
      repeat (2) @(negedge clock_i);
      arst_n_i = 1;
      @(posedge clock_i); #1 chk("entry", entry, 1);
      chk("mode", spec, 1);
      @(negedge clock_i) rdc(8'h15, 8'h0e);
      m.acc(1, 8'h11, 8'h80);
      m.acc(1, 8'h11, 8'h40);
      rdc(8'h11, 8'h40);
      for (i = 0; i < 24; i++) begin
         p = $urandom;
         m.acc(1, 8'h15, {4'h0, p});
         {ca, dir, dv, da} = {$urandom, $urandom};
         #1 chk("global", cg, dir ? xmap({8'h40, ca[7:0]}, p) : xmap(ca, p));
      end
      dv = 5'h00;
      fp = $urandom;
      far = 1;
      @(negedge clock_i) far = 0;
      {dir, ca} = {1'b0, 16'h8123};
      #1 chk("far page", cg, xmap(ca, fp));
      da = 16'hff00;
      dv = 5'h01;
      #1 chk("select", sel, 0);
      dv = 5'h05;
      #1 chk("select", sel, 1);
      m.acc(1, 8'h16, 8'h09);
      rdc(8'h16, 8'h09);
      dv = 5'h18;
      da = 16'h8123;
      #1 chk("dbg global", dg, {4'h9, 14'h0123});
      dv = 5'h10;
      #1 chk("dbg global", dg, {fp, 14'h0123});
      m.acc(1, 8'h15, 8'h0f);
      da = 16'hbf10;
      dv = 5'h05;
      #1 chk("select", sel, 1);
      sec = 1;
      m.acc(1, 8'h0b, 8'h00);
      chk("mode", spec, 1);
      sec = 0;
      m.acc(1, 8'h0b, 8'h00);
      chk("mode", spec, 0);
      m.acc(1, 8'h0b, 8'h80);
      a_ns = 1;
      m.acc(1, 8'h0b, 8'h80);
      rdc(8'h0b, 8'h00);
      rdc(8'h30, 8'h00);
      {pin, arst_n_i} = 2'b00;
      @(negedge clock_i) arst_n_i = 1;
      @(posedge clock_i); #1 chk("entry", entry, 0);
      chk("mode", spec, 0);
      @(negedge clock_i) m.acc(1, 8'h11, 8'h12);
      m.acc(1, 8'h11, 8'h34);
      rdc(8'h11, 8'h12);
      final_report;
   end
endmodule // mmpc_page_ctrl_tb
